// file: design/fci_host.sv
// flash command host: apb register slave that sequences flash command cycles
// assumes the flash pins are synchronous to mclk and the dq wire is resolved outside
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "fci_params.svh"

module fci_host #(
  parameter int RESET_LOW_CYC   = `FCI_RESET_LOW_CYC,
  parameter int RECOVER_CYC     = `FCI_RECOVER_CYC,
  parameter int BUSY_SETTLE_CYC = `FCI_BUSY_SETTLE_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             byte_n,
  output logic             reset_powerdown_n,
  output logic [18:0]      a,
  output logic             a_lsb,
  output logic [15:0]      dq_out,
  output logic             dq_oe_n,
  input  wire logic [15:0] dq_in,
  input  wire logic        ready_busy_n
);

  fci_pkg::fci_state_t state;
  fci_pkg::fci_op_t    op;
  logic [15:0]         cnt;
  logic [19:0]         addr_reg;
  logic [15:0]         wdata_reg;
  logic [2:0]          ctrl;
  logic                done_flag;
  logic                refused_flag;
  logic [15:0]         rdata_reg;
  logic                cyc_start;
  logic                cyc_write;
  logic [18:0]         cyc_addr;
  logic [15:0]         cyc_data;
  logic                cyc_done;
  logic [15:0]         cyc_rdata;
  logic                setup_ph;
  logic                wr_acc;
  logic                cmd_wr;
  logic                idle;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] first_code(input fci_pkg::fci_op_t o, input logic alt);
    unique case (o)
      fci_pkg::FCI_OP_READ_ARRAY:   first_code = `FCI_C_READ_ARRAY;                       // R3
      fci_pkg::FCI_OP_READ_ID:      first_code = `FCI_C_READ_ID;                          // R3
      fci_pkg::FCI_OP_READ_STATUS:  first_code = `FCI_C_READ_STATUS;                      // R15
      fci_pkg::FCI_OP_CLEAR_STATUS: first_code = `FCI_C_CLEAR_STATUS;                     // R15
      fci_pkg::FCI_OP_BLOCK_ERASE:  first_code = `FCI_C_BLOCK_ERASE;                      // R16
      fci_pkg::FCI_OP_CHIP_ERASE:   first_code = `FCI_C_CHIP_ERASE;                       // R17
      fci_pkg::FCI_OP_PROGRAM:      first_code = alt ? `FCI_C_PROGRAM_ALT : `FCI_C_PROGRAM; // R18
      fci_pkg::FCI_OP_SET_BLOCK,
      fci_pkg::FCI_OP_CLEAR_LOCKS,
      fci_pkg::FCI_OP_SET_PERM:     first_code = `FCI_C_LOCK_SETUP;                       // R19
      fci_pkg::FCI_OP_OTP_PROGRAM,
      fci_pkg::FCI_OP_OTP_LOCK:     first_code = `FCI_C_OTP_PROGRAM;                      // R4
      default:                      first_code = `FCI_C_READ_ARRAY;
    endcase
  endfunction : first_code

  // operations that run an algorithm and so hold ready_busy_n low
  function automatic logic is_long(input fci_pkg::fci_op_t o);
    is_long = (o == fci_pkg::FCI_OP_BLOCK_ERASE) || (o == fci_pkg::FCI_OP_CHIP_ERASE) ||
              (o == fci_pkg::FCI_OP_PROGRAM) || (o == fci_pkg::FCI_OP_SET_BLOCK) ||
              (o == fci_pkg::FCI_OP_CLEAR_LOCKS) || (o == fci_pkg::FCI_OP_SET_PERM) ||
              (o == fci_pkg::FCI_OP_OTP_PROGRAM) || (o == fci_pkg::FCI_OP_OTP_LOCK);
  endfunction : is_long

  function automatic logic [15:0] second_data(input fci_pkg::fci_op_t o, input logic [15:0] wd);
    unique case (o)
      fci_pkg::FCI_OP_BLOCK_ERASE,
      fci_pkg::FCI_OP_CHIP_ERASE,
      fci_pkg::FCI_OP_CLEAR_LOCKS: second_data = {8'h00, `FCI_C_CONFIRM};    // R16 R17 R20
      fci_pkg::FCI_OP_SET_BLOCK:   second_data = {8'h00, `FCI_C_SET_BLOCK};  // R19
      fci_pkg::FCI_OP_SET_PERM:    second_data = {8'h00, `FCI_C_SET_PERM};   // R19
      fci_pkg::FCI_OP_OTP_LOCK:    second_data = `FCI_OTP_LOCK_DATA;         // R6
      default:                     second_data = wd;                         // R4 R18
    endcase
  endfunction : second_data

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pready & pwrite;
  assign cmd_wr   = wr_acc & (paddr == `FCI_OFS_CMD);
  assign idle     = (state == fci_pkg::FCI_ST_IDLE);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (setup_ph) begin
        unique case (paddr)
          `FCI_OFS_CMD:    prdata <= {28'h0000000, op};
          `FCI_OFS_ADDR:   prdata <= {12'h000, addr_reg};
          `FCI_OFS_WDATA:  prdata <= {16'h0000, wdata_reg};
          `FCI_OFS_CTRL:   prdata <= {29'h00000000, ctrl};
          `FCI_OFS_STATUS: prdata <= {27'h0000000, ~reset_powerdown_n, ready_busy_n,
                                      refused_flag, done_flag, ~idle};
          `FCI_OFS_RDATA:  prdata <= {16'h0000, rdata_reg};
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_reg  <= 20'h00000;
      wdata_reg <= 16'h0000;
      ctrl      <= 3'h0;
    end else if (wr_acc) begin
      if (paddr == `FCI_OFS_ADDR)  addr_reg  <= pwdata[19:0];
      if (paddr == `FCI_OFS_WDATA) wdata_reg <= pwdata[15:0];
      if (paddr == `FCI_OFS_CTRL)  ctrl      <= pwdata[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      byte_n <= 1'b1;
    end else begin
      byte_n <= ~ctrl[`FCI_CTRL_BYTE_MODE];                                  // R25
    end
  end

  // a command while busy is dropped; the set wins over a clearing write
  always_ff @(posedge mclk) begin
    if (rst) begin
      refused_flag <= 1'b0;
    end else if (cmd_wr && !idle) begin
      refused_flag <= 1'b1;
    end else if (wr_acc && paddr == `FCI_OFS_STATUS && pwdata[`FCI_ST_REFUSED]) begin
      refused_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state             <= fci_pkg::FCI_ST_RESET;
      cnt               <= 16'(RESET_LOW_CYC - 1);
      reset_powerdown_n <= 1'b0;
      op                <= fci_pkg::FCI_OP_READ;
      done_flag         <= 1'b0;
      rdata_reg         <= 16'h0000;
      cyc_start         <= 1'b0;
      cyc_write         <= 1'b0;
      cyc_addr          <= 19'h00000;
      cyc_data          <= 16'h0000;
    end else begin
      cyc_start <= 1'b0;
      if (ctrl[`FCI_CTRL_HOLD_RESET] && state != fci_pkg::FCI_ST_RESET) begin
        // abort the running sequence, though a started bus cycle still runs to its end; the flash drops its algorithm on this edge
        state             <= fci_pkg::FCI_ST_RESET;                           // R23
        cnt               <= 16'(RESET_LOW_CYC - 1);
        reset_powerdown_n <= 1'b0;
      end else begin
        unique case (state)
          fci_pkg::FCI_ST_RESET: begin
            if (cnt != 16'h0000) begin
              cnt <= cnt - 16'h0001;
            end else if (!ctrl[`FCI_CTRL_HOLD_RESET]) begin
              reset_powerdown_n <= 1'b1;
              state             <= fci_pkg::FCI_ST_RECOVER;
              cnt               <= 16'(RECOVER_CYC - 1);
            end
          end
          fci_pkg::FCI_ST_RECOVER: begin
            // flash comes back in read array mode, no command needed
            if (cnt == 16'h0000) state <= fci_pkg::FCI_ST_IDLE;              // R22
            else cnt <= cnt - 16'h0001;
          end
          fci_pkg::FCI_ST_IDLE: begin
            if (cmd_wr) begin
              op        <= fci_pkg::fci_op_t'(pwdata[3:0]);
              done_flag <= 1'b0;
              cyc_start <= 1'b1;
              cyc_addr  <= addr_reg[18:0];
              if (fci_pkg::fci_op_t'(pwdata[3:0]) == fci_pkg::FCI_OP_READ) begin
                cyc_write <= 1'b0;
                state     <= fci_pkg::FCI_ST_SECOND;
              end else begin
                cyc_write <= 1'b1;
                cyc_data  <= {8'h00, first_code(fci_pkg::fci_op_t'(pwdata[3:0]),
                                                ctrl[`FCI_CTRL_ALT_PROG])};
                state     <= fci_pkg::FCI_ST_FIRST;
              end
            end
          end
          fci_pkg::FCI_ST_FIRST: begin
            if (cyc_done) begin
              if (is_long(op)) begin
                cyc_start <= 1'b1;
                cyc_data  <= second_data(op, wdata_reg);
                cyc_addr  <= (op == fci_pkg::FCI_OP_OTP_LOCK) ? `FCI_OTP_LOCK_ADDR
                                                             : addr_reg[18:0];  // R6
                state     <= fci_pkg::FCI_ST_SECOND;
              end else begin
                done_flag <= 1'b1;
                state     <= fci_pkg::FCI_ST_IDLE;
              end
            end
          end
          fci_pkg::FCI_ST_SECOND: begin
            if (cyc_done) begin
              if (!cyc_write) begin
                rdata_reg <= cyc_rdata;
              end
              if (cyc_write) begin
                state <= fci_pkg::FCI_ST_SETTLE;
                cnt   <= 16'(BUSY_SETTLE_CYC - 1);
              end else begin
                done_flag <= 1'b1;
                state     <= fci_pkg::FCI_ST_IDLE;
              end
            end
          end
          fci_pkg::FCI_ST_SETTLE: begin
            // give the flash time to pull ready_busy_n low before polling it
            if (cnt == 16'h0000) state <= fci_pkg::FCI_ST_WAIT_RB;
            else cnt <= cnt - 16'h0001;
          end
          fci_pkg::FCI_ST_WAIT_RB: begin
            if (ready_busy_n) begin                                          // R14
              done_flag <= 1'b1;
              state     <= fci_pkg::FCI_ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pin cycle engine
  // ---------------------------------------------------------------
  fci_bus_cycle u_cycle (
    .mclk     (mclk),
    .rst      (rst),
    .start    (cyc_start),
    .is_write (cyc_write),
    .addr     (cyc_addr),
    .addr_lsb (addr_reg[`FCI_ADDR_LSB_BIT]),
    .wdata    (cyc_data),
    .byte_mode(ctrl[`FCI_CTRL_BYTE_MODE]),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .ce_n     (ce_n),
    .oe_n     (oe_n),
    .we_n     (we_n),
    .a        (a),
    .a_lsb    (a_lsb),
    .dq_out   (dq_out),
    .dq_oe_n  (dq_oe_n),
    .dq_in    (dq_in)
  );

endmodule : fci_host

// file: design/fci_params.svh
// constants for the flash command host: register map, fields, command codes and timing
// assumes a 250 MHz mclk and a parallel flash that latches commands on the strobe rising edge
//
// Functional notes
// R1 - the flash refuses erase of its one-time-programmable block; only its program command alters it
// R2 - factory OTP area is read-only; customer area programs until locked, then permanently protected
// R3 - 90H enters configuration read of the OTP block; FFH returns to array reads
// R4 - OTP program is C0H followed by data written at its target OTP address
// R5 - failed OTP program sets program_fail_flag; locked block also sets protect_fail_flag
// R6 - OTP lock is C0H then data FFFDH written to OTP offset 80H
// R7 - lock word bit 0 is factory lock, bit 1 customer lock; 0 means locked
// R8 - a lock-information bit once locked never returns to unlocked
// R9 - address and data are latched on the first rising edge of write strobe or chip select
// R10 - commands are taken only with write strobe and chip select both low, any address
// R11 - without program_voltage_valid the flash still reads but refuses erase, program and lock
// R12 - bus mode comes from control pins; reset, standby and output disable float the data pins
// R13 - output enable and write strobe are never low together
// R14 - ready_busy_n is low while an erase, program or lock algorithm runs, else floating
// R15 - FFH read array, 50H clear status, 70H read status; then reads return status
// R16 - block erase is 20H then D0H at an address inside the block
// R17 - full chip erase is 30H then D0H at any address
// R18 - word or byte program is 40H or 10H then data at the target address
// R19 - 60H then 01H at block address sets its lock; 60H then F1H sets permanent lock
// R20 - 60H then D0H at any address clears the block lock bits
// R21 - single-cycle suspend pauses erase or program; resume continues it
// R22 - after reset the flash is in read array mode with status 80H
// R23 - reset_powerdown_n low aborts a running operation; ready_busy_n stays low until done
// R24 - undefined codes or mismatched second cycles start nothing and flag a sequence error
// R25 - with byte mode only the low eight data lines move and the extra low address selects the byte
`ifndef FCI_PARAMS_SVH
`define FCI_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses on apb)
// ---------------------------------------------------------------
`define FCI_OFS_CMD      8'h00
`define FCI_OFS_ADDR     8'h04
`define FCI_OFS_WDATA    8'h08
`define FCI_OFS_CTRL     8'h0c
`define FCI_OFS_STATUS   8'h10
`define FCI_OFS_RDATA    8'h14

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FCI_CTRL_BYTE_MODE   0
`define FCI_CTRL_HOLD_RESET  1
`define FCI_CTRL_ALT_PROG    2
`define FCI_ST_BUSY          0
`define FCI_ST_DONE          1
`define FCI_ST_REFUSED       2
`define FCI_ST_READY         3
`define FCI_ST_IN_RESET      4
`define FCI_ADDR_LSB_BIT     19

// ---------------------------------------------------------------
// flash command codes
// ---------------------------------------------------------------
`define FCI_C_READ_ARRAY   8'hff
`define FCI_C_READ_ID      8'h90
`define FCI_C_READ_STATUS  8'h70
`define FCI_C_CLEAR_STATUS 8'h50
`define FCI_C_BLOCK_ERASE  8'h20
`define FCI_C_CHIP_ERASE   8'h30
`define FCI_C_PROGRAM      8'h40
`define FCI_C_PROGRAM_ALT  8'h10
`define FCI_C_LOCK_SETUP   8'h60
`define FCI_C_CONFIRM      8'hd0
`define FCI_C_SET_BLOCK    8'h01
`define FCI_C_SET_PERM     8'hf1
`define FCI_C_OTP_PROGRAM  8'hc0
`define FCI_OTP_LOCK_DATA  16'hfffd
`define FCI_OTP_LOCK_ADDR  19'h00080

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FCI_CLK_NS          4
`define FCI_RESET_LOW_NS    100
`define FCI_RESET_LOW_CYC   ((`FCI_RESET_LOW_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_RECOVER_CYC     32
`define FCI_BUSY_SETTLE_CYC 8
`define FCI_SETUP_CYC       3
`define FCI_PULSE_CYC       5
`define FCI_HOLD_CYC        2

`endif

// file: design/fci_pkg.sv
// types for the flash command host
// assumes nothing beyond the constants header
package fci_pkg;

  typedef enum logic [3:0] {
    FCI_OP_READ         = 4'h0,
    FCI_OP_READ_ARRAY   = 4'h1,
    FCI_OP_READ_ID      = 4'h2,
    FCI_OP_READ_STATUS  = 4'h3,
    FCI_OP_CLEAR_STATUS = 4'h4,
    FCI_OP_BLOCK_ERASE  = 4'h5,
    FCI_OP_CHIP_ERASE   = 4'h6,
    FCI_OP_PROGRAM      = 4'h7,
    FCI_OP_SET_BLOCK    = 4'h8,
    FCI_OP_CLEAR_LOCKS  = 4'h9,
    FCI_OP_SET_PERM     = 4'ha,
    FCI_OP_OTP_PROGRAM  = 4'hb,
    FCI_OP_OTP_LOCK     = 4'hc
  } fci_op_t;

  typedef enum logic [6:0] {
    FCI_ST_RESET   = 7'b0000001,
    FCI_ST_RECOVER = 7'b0000010,
    FCI_ST_IDLE    = 7'b0000100,
    FCI_ST_FIRST   = 7'b0001000,
    FCI_ST_SECOND  = 7'b0010000,
    FCI_ST_SETTLE  = 7'b0100000,
    FCI_ST_WAIT_RB = 7'b1000000
  } fci_state_t;

  typedef enum logic [3:0] {
    FCI_CY_IDLE   = 4'b0001,
    FCI_CY_SETUP  = 4'b0010,
    FCI_CY_STROBE = 4'b0100,
    FCI_CY_HOLD   = 4'b1000
  } fci_cycle_t;

endpackage : fci_pkg

// file: design/fci_bus_cycle.sv
// one flash bus cycle, read or write, on the chip select / output enable / write strobe pins
// assumes the caller pulses start only while idle and waits for done
`timescale 1ns/1ps
`include "fci_params.svh"

module fci_bus_cycle #(
  parameter int SETUP_CYC = `FCI_SETUP_CYC,
  parameter int PULSE_CYC = `FCI_PULSE_CYC,
  parameter int HOLD_CYC  = `FCI_HOLD_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // request
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [18:0] addr,
  input  wire logic        addr_lsb,
  input  wire logic [15:0] wdata,
  input  wire logic        byte_mode,
  output logic             done,
  output logic [15:0]      rdata,
  // flash pins
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [18:0]      a,
  output logic             a_lsb,
  output logic [15:0]      dq_out,
  output logic             dq_oe_n,
  input  wire logic [15:0] dq_in
);

  fci_pkg::fci_cycle_t state;
  logic [7:0]          cnt;
  logic                wr;
  logic                last;

  assign last = (cnt == 8'h00);

  // ---------------------------------------------------------------
  // phase sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= fci_pkg::FCI_CY_IDLE;
      cnt   <= 8'h00;
      wr    <= 1'b0;
    end else begin
      unique case (state)
        fci_pkg::FCI_CY_IDLE: begin
          if (start) begin
            state <= fci_pkg::FCI_CY_SETUP;
            cnt   <= 8'(SETUP_CYC - 1);
            wr    <= is_write;
          end
        end
        fci_pkg::FCI_CY_SETUP: begin
          if (last) begin
            state <= fci_pkg::FCI_CY_STROBE;
            cnt   <= 8'(PULSE_CYC - 1);
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        fci_pkg::FCI_CY_STROBE: begin
          if (last) begin
            state <= fci_pkg::FCI_CY_HOLD;
            cnt   <= 8'(HOLD_CYC - 1);
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        fci_pkg::FCI_CY_HOLD: begin
          if (last) begin
            state <= fci_pkg::FCI_CY_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // the strobe rises while chip select is still low, so the strobe edge is the latching edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      ce_n    <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
      a       <= 19'h00000;
      a_lsb   <= 1'b0;
      dq_out  <= 16'h0000;
      dq_oe_n <= 1'b1;
      done    <= 1'b0;
      rdata   <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (state == fci_pkg::FCI_CY_IDLE && start) begin
        ce_n    <= 1'b0;
        a       <= addr;
        a_lsb   <= byte_mode & addr_lsb;                          // R25
        dq_out  <= byte_mode ? {8'h00, wdata[7:0]} : wdata;       // R25
        dq_oe_n <= ~is_write;                                     // R12
      end
      if (state == fci_pkg::FCI_CY_SETUP && last) begin
        we_n <= ~wr;                                              // R10
        oe_n <= wr;                                               // R13
      end
      if (state == fci_pkg::FCI_CY_STROBE && last) begin
        we_n <= 1'b1;                                             // R9
        oe_n <= 1'b1;
        if (!wr) begin
          rdata <= byte_mode ? {8'h00, dq_in[7:0]} : dq_in;       // R25
        end
      end
      if (state == fci_pkg::FCI_CY_HOLD && last) begin
        ce_n    <= 1'b1;                                          // R12
        dq_oe_n <= 1'b1;
        done    <= 1'b1;
      end
    end
  end

endmodule : fci_bus_cycle

// file: tb/fci_host_props.sv
// checker on the flash host ports
// assumes it is bound into fci_host
`timescale 1ns/1ps
module fci_host_props (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // flash pins
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        byte_n,
  input wire logic        reset_powerdown_n,
  input wire logic [18:0] a,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_we_low;
    !we_n [*5] ##1 we_n;
  endsequence
  sequence s_ce_tail;
    !ce_n ##1 !ce_n ##1 ce_n;
  endsequence
  AST_OE_WE: assert property (oe_n || we_n) else $error("oe_n with we_n");
  AST_WE_CE: assert property (!we_n |-> !ce_n) else $error("we_n outside ce_n");
  AST_WE_PULSE: assert property ($fell(we_n) |-> s_we_low) else $error("we_n width");
  AST_WE_FIRST: assert property ($rose(we_n) |-> s_ce_tail) else $error("ce_n rose first");
  AST_HOLD: assert property (!ce_n && $past(!ce_n) |-> $stable({a, dq_out}))
    else $error("a or dq moved");
  AST_RP_IDLE: assert property (!reset_powerdown_n |-> ce_n && oe_n && we_n && dq_oe_n)
    else $error("strobe in reset");
  AST_DQ_DIR: assert property (!dq_oe_n |-> oe_n) else $error("dq driven in read");
  AST_BYTE: assert property (!byte_n && !dq_oe_n |-> dq_out[15:8] == 8'h00)
    else $error("upper dq in byte mode");
  AST_APB: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready timing");
  AST_ERR: assert property (pslverr |-> pready) else $error("pslverr alone");
endmodule : fci_host_props

// file: tb/fci_flash_model.sv
// behavioural flash: command decoder, status, otp lock word, ready_busy
// assumes the dq wire is resolved outside and ready_busy has a pull-up
`timescale 1ns/1ps
module fci_flash_model #(
  parameter int BUSY_NS = 200
) (
  // control pins
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        reset_powerdown_n,
  // address and data
  input wire logic [18:0] a,
  input wire logic [15:0] dq,
  output logic [15:0]     dq_rd,
  output logic            rb_low,
  // command log
  output logic [15:0]     prev_d,
  output logic [15:0]     cap_d,
  output logic [18:0]     cap_a,
  output int              nwr
);
  logic [7:0] sr = 8'h80, setup = 8'h00;
  logic [1:0] mode = 2'd0;
  logic [1:0] lock = 2'b10;
  logic       ok;
  event       go;
  wire        wr = !we_n && !ce_n;
  wire        drv = !ce_n && !oe_n && we_n && reset_powerdown_n;
  wire [15:0] val = mode == 2'd1 ? {8'h00, sr} : mode == 2'd2 ? {14'h3fff, lock} : 16'hffff;
  // released bus shows the inverse: no stale pass
  assign dq_rd = drv ? val : ~val;
  initial begin
    {prev_d, cap_d, cap_a, rb_low} = '0;
    nwr = 0;
  end
  always @(negedge reset_powerdown_n) begin
    sr = 8'h80;
    mode = 2'd0;
    setup = 8'h00;
  end
  always @(go) begin
    rb_low = 1'b1;
    sr[7] = 1'b0;
    #BUSY_NS;
    rb_low = 1'b0;
    sr[7] = 1'b1;
  end
  always @(negedge wr) begin
    prev_d = cap_d;
    cap_d = dq;
    cap_a = a;
    nwr++;
    ok = dq[7:0] == 8'hd0 || setup != 8'h20 && setup != 8'h30 && (setup != 8'h60 || dq[7:0] inside {8'h01, 8'hf1});
    if (setup != 8'h00) begin
      if (setup == 8'hc0 && !lock[1]) sr = sr | 8'h12;
      else if (setup == 8'hc0 && a == 19'h80) lock = lock & dq[1:0];
      else if (!ok) sr = sr | 8'h30;
      else ->go;
      mode = 2'd1;
      setup = 8'h00;
    end else case (dq[7:0])
      8'hff: mode = 2'd0;
      8'h90: mode = 2'd2;
      8'h70: mode = 2'd1;
      8'h50: sr = sr & 8'hc5;
      8'h20, 8'h30, 8'h40, 8'h10, 8'h60, 8'hc0: setup = dq[7:0];
      default: sr = sr | 8'h30;
    endcase
  end
endmodule : fci_flash_model

// file: tb/fci_host_tb_top.sv
// self-checking bench for the flash command host
// assumes the flash model on the far side
`timescale 1ns/1ps
module fci_host_tb_top;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, se;
  logic        ce_n, oe_n, we_n, byte_n, reset_powerdown_n, dq_oe_n, a_lsb, rb_low;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [18:0] a, cap_a;
  logic [15:0] dq_out, dq_rd, prev_d, cap_d;
  int          nwr, n0, failures, cmp_count;
  logic [7:0]  c1 [12] = '{8'hff, 8'h90, 8'h70, 8'h50, 8'h20, 8'h30, 8'h40, 8'h60, 8'h60, 8'h60, 8'hc0, 8'hc0};
  logic [15:0] c2 [12] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hd0, 16'hd0, 16'h3c5a, 16'h1, 16'hd0, 16'hf1,
                           16'h3c5a, 16'hfffd};
  wire  [15:0] dq_in = dq_oe_n ? dq_rd : dq_out;
  wire         ready_busy_n = !rb_low;
  fci_host #(.RESET_LOW_CYC(4), .RECOVER_CYC(4), .BUSY_SETTLE_CYC(2)) fci_host_i (.mclk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ce_n, .oe_n, .we_n, .byte_n, .reset_powerdown_n, .a,
    .a_lsb, .dq_out, .dq_oe_n, .dq_in, .ready_busy_n);
  fci_flash_model fci_flash_model_i (.ce_n, .oe_n, .we_n, .reset_powerdown_n, .a, .dq(dq_in), .dq_rd, .rb_low,
    .prev_d, .cap_d, .cap_a, .nwr);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic summarize();
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (k >= 20) begin
      failures++;
      summarize();
    end
  endtask : apb
  task automatic poll(input logic [31:0] m, v);
    int k = 0;
    do begin
      apb(1'b0, 8'h10, 32'h0);
      k++;
    end while ((q & m) !== v && k < 300);
    if (k >= 300) begin
      failures++;
      summarize();
    end
  endtask : poll
  task automatic run(input logic [3:0] op);
    apb(1'b1, 8'h00, {28'h0, op});
    poll(32'h3, 32'h2);
  endtask : run
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, failures, cmp_count} = '0;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(reset_powerdown_n, 1'b0);
    poll(32'h1f, 32'h08);
    apb(1'b1, 8'h04, 32'h12345);
    apb(1'b1, 8'h08, 32'h3c5a);
    for (int i = 0; i < 12; i++) begin
      n0 = nwr;
      run(4'(i + 1));
      chk(nwr - n0, i < 4 ? 1 : 2);
      chk(cap_d, i < 4 ? {8'h00, c1[i]} : c2[i]);
      if (i > 3) chk(prev_d, {8'h00, c1[i]});
      if (i inside {4, 6, 7, 10, 11}) chk(cap_a, i == 11 ? 32'h80 : 32'h12345);
    end
    apb(1'b1, 8'h00, 32'h5);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(q[2], 1'b1);
    poll(32'h3, 32'h2);
    chk(cap_d, 16'h00d0);
    run(4'hb);
    run(4'h3);
    run(4'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h92);
    apb(1'b1, 8'h04, 32'h80);
    run(4'h2);
    run(4'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(q, 32'hfffc);
    apb(1'b0, 8'h20, 32'h0);
    chk(se, 1'b1);
    apb(1'b1, 8'h0c, 32'h5);
    apb(1'b1, 8'h04, 32'h80007);
    run(4'h7);
    chk(prev_d, 16'h0010);
    chk(cap_d, 16'h005a);
    apb(1'b1, 8'h0c, 32'h7);
    poll(32'h10, 32'h10);
    apb(1'b1, 8'h0c, 32'h5);
    poll(32'h11, 32'h0);
    summarize();
  end
endmodule : fci_host_tb_top
bind fci_host fci_host_props fci_host_props_i (.mclk, .rst, .psel, .penable, .pready, .pslverr, .ce_n, .oe_n,
  .we_n, .byte_n, .reset_powerdown_n, .a, .dq_out, .dq_oe_n);
